// File: dv/spq_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// bus slave: answers a short reset low with presence, and in talk mode pulls
// zero bits of pattern low across the sample point of each slot
module spq_slave_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic oe,
  input wire logic present,
  input wire logic talk,
  input wire logic [7:0] pattern,
  output logic pull
);
  int low_reg;
  int pull_reg;
  logic [2:0] idx_reg;
  logic oe_d_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_reg <= 0;
      pull_reg <= 0;
      idx_reg <= 3'h0;
      oe_d_reg <= 1'b0;
    end else begin
      oe_d_reg <= oe;
      low_reg <= oe ? low_reg + 1 : 0;
      if (pull_reg != 0) pull_reg <= pull_reg - 1;
      if (!oe && oe_d_reg && low_reg < 400 && present) pull_reg <= 60;
      if (oe && !oe_d_reg && talk) begin
        idx_reg <= idx_reg + 3'h1;
        if (!pattern[idx_reg]) pull_reg <= 1200;
      end
      if (!talk) idx_reg <= 3'h0;
    end
  end
  assign pull = pull_reg != 0;
endmodule : spq_slave_model
`default_nettype wire

// File: dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk = 0;
  logic rst, cvalid, rready, present, talk;
  logic [7:0] cdata, pat, b;
  logic [2:0] dur;
  logic cready, rvalid, ow_out, ow_oe, spu_en, dmode, armed, pull;
  logic [7:0] rdata;
  logic [7:0] expq[$];
  logic [7:0] pc[4] = '{8'hED, 8'hEF, 8'hFD, 8'hFF};
  int err_count = 0, cmp_count = 0, run = 0, last_len = 0, i;
  always #5 mclk = ~mclk;
  spq_sequencer #(.SLOT_CYC(1300), .LOW0_CYC(1200), .RST_LOW_CYC(100), .RST_SMP_CYC(120),
    .RST_TOT_CYC(200), .SPU_BASE_CYC(16)) DUT (.MCLK(mclk), .SYS_RST(rst),
    .CMD_VALID(cvalid), .CMD_DATA(cdata), .CMD_READY(cready), .RSP_VALID(rvalid),
    .RSP_DATA(rdata), .RSP_READY(rready), .SPU_DUR(dur), .OW_IN(!(ow_oe | pull)),
    .OW_OUT(ow_out), .OW_OE(ow_oe), .SPU_EN(spu_en), .DATA_MODE(dmode), .SPU_ARMED(armed));
  spq_slave_model slave (.clk(mclk), .rst(rst), .oe(ow_oe), .present(present),
    .talk(talk), .pattern(pat), .pull(pull));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic fail_to;
    err_count++;
    $display("BAD %0t wait ran out", $time);
    tally_and_finish();
  endtask : fail_to
  // host side of response buffer stalls at random
  always @(posedge mclk) begin
    rready <= ($urandom % 4) != 0;
    if (spu_en) run <= run + 1;
    else if (run != 0) begin
      last_len <= run;
      run <= 0;
    end
    if (rvalid === 1'b1 && rready && !rst) begin
      if (expq.size() == 0) begin
        err_count++;
        $display("BAD %0t unexpected response %h", $time, rdata);
      end else chk(rdata, expq.pop_front());
    end
  end
  // waits for buffer room before handing over the byte
  task automatic send(input logic [7:0] v);
    int k;
    @(posedge mclk);
    cvalid <= 1'b1;
    cdata <= v;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (cready !== 1'b1 && k < 20000);
    if (k >= 20000) fail_to();
    cvalid <= 1'b0;
  endtask : send
  task automatic xfer(input logic [7:0] v, input logic [7:0] e);
    expq.push_back(e);
    send(v);
  endtask : xfer
  task automatic drain;
    int k;
    k = 0;
    while (expq.size() != 0 && k < 30000) begin
      @(posedge mclk);
      k++;
    end
    if (expq.size() != 0) fail_to();
    repeat (3) @(posedge mclk);
  endtask : drain
  task automatic do_reset;
    rst <= 1'b1;
    cvalid <= 1'b0;
    repeat (5) @(posedge mclk);
    chk({1'b0, ow_out, spu_en, dmode, armed, ow_oe, rvalid, cready}, 8'h00);
    rst <= 1'b0;
    expq.delete();
    repeat (2) @(posedge mclk);
  endtask : do_reset
  initial begin
    cdata <= 8'h00;
    present <= 1'b1;
    talk <= 1'b0;
    pat <= 8'hFF;
    dur <= 3'h0;
    void'($urandom(32'h4f161082));
    do_reset();
    xfer(8'hC1, 8'hC9);
    drain();
    present <= 1'b0;
    xfer(8'hC1, 8'hCD);
    drain();
    present <= 1'b1;
    xfer(8'h91, 8'h93);
    xfer(8'h81, 8'h80);
    send(8'hE1);
    drain();
    chk({7'h0, dmode}, 8'h01);
    for (i = 0; i < 4; i++) begin
      b = 8'($urandom);
      if (b == 8'hE3) b = 8'h00;
      xfer(b, b);
    end
    xfer(8'hF1, 8'hF1);
    drain();
    pat <= 8'($urandom);
    talk <= 1'b1;
    @(posedge mclk);
    xfer(8'hFF, pat);
    drain();
    talk <= 1'b0;
    send(8'hE3);
    drain();
    chk({7'h0, dmode}, 8'h00);
    for (i = 0; i < 4; i++) begin
      dur <= i[2:0];
      @(posedge mclk);
      xfer(pc[i], pc[i] & 8'hFC);
      drain();
      chk(8'(last_len), 8'(16 << i));
      chk({7'h0, armed}, {7'h0, pc[i][1]});
    end
    dur <= 3'h7;
    expq.push_back(8'hEC);
    send(8'hEF);
    repeat (50) @(posedge mclk);
    chk({7'h0, spu_en}, 8'h01);
    send(8'hF1);
    drain();
    dur <= 3'h1;
    send(8'hE1);
    expq.push_back(8'h44);
    xfer(8'h44, 8'hEC);
    drain();
    chk(8'(last_len), 8'd32);
    send(8'hE3);
    dur <= 3'h7;
    expq.push_back(8'hEC);
    send(8'hED);
    send(8'hF1);
    drain();
    chk({7'h0, armed}, 8'h00);
    dur <= 3'h2;
    expq.push_back(8'h80);
    xfer(8'h83, 8'h80);
    drain();
    chk(8'(last_len), 8'd64);
    dur <= 3'h7;
    xfer(8'h93, 8'h93);
    drain();
    repeat (400) @(posedge mclk);
    chk({7'h0, spu_en}, 8'h01);
    xfer(8'hF1, 8'h90);
    drain();
    chk({7'h0, spu_en}, 8'h00);
    expq.push_back(8'hEC);
    send(8'hEF);
    send(8'hF1);
    send(8'hE1);
    xfer(8'h3C, 8'h3C);
    drain();
    send(8'hF1);
    repeat (500) @(posedge mclk);
    chk({7'h0, spu_en}, 8'h01);
    do_reset();
    xfer(8'hC1, 8'hC9);
    drain();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire

// File: rtl/spq_pkg.sv
package spq_pkg;
  localparam int CLK_NS = 10;
  localparam int SLOT_US = 60;
  localparam int LOW1_US = 8;
  localparam int DSO_US = 3;
  localparam int LOW0_US = 57;
  localparam int RST_LOW_US = 512;
  localparam int RST_SMP_US = 584;
  localparam int RST_TOT_US = 1024;
  localparam int SPU_BASE_US = 512;
  localparam logic [7:0] CMD_DATA = 8'hE1;
  localparam logic [7:0] CMD_CMDM = 8'hE3;
  localparam logic [7:0] CMD_TERM = 8'hF1;
  localparam logic [7:0] CMD_RESET = 8'hC1;
  localparam logic [7:0] PULSE_MASK = 8'hED;
  localparam logic [7:0] PULSE_VAL = 8'hED;
  localparam logic [7:0] SB_MASK = 8'hED;
  localparam logic [7:0] SB_VAL = 8'h81;
  localparam logic [7:0] RESP_MASK = 8'hFC;
  localparam logic [7:0] RESP_PRES = 8'hC9;
  localparam logic [7:0] RESP_NOPRES = 8'hCD;
  localparam logic [7:0] RESP_SPU = 8'hEC;
  localparam int ARM_BIT = 1;
  localparam int SB_BIT = 4;
  localparam logic [2:0] DUR_INF = 3'h7;
  localparam logic [2:0] LAST_BIT = 3'h7;
  function automatic int us2cyc(input int us);
    return (us * 1000 + CLK_NS - 1) / CLK_NS;
  endfunction : us2cyc
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RST = 5'h02,
    ST_SLOT = 5'h04,
    ST_SPU = 5'h08,
    ST_FIN = 5'h10
  } spq_state_t;
endpackage : spq_pkg

// File: rtl/spq_sequencer.sv
// Operation
// - pulse command with bit 1 set arms the data-mode strong pull-up
// - armed in data mode: strong pull-up after every transferred byte
// - after eighth slot: pull-up on and data response sent at once
// - data-mode pull-up ends at its duration, then pulse response sent
// - F1 has no effect on a data-mode pull-up; host uses finite duration
// - infinite data-mode pull-up sticks until a reset
// - single bit command bit 1 enables pull-up after its slot, no arming
// - single bit pull-up may use any duration including infinite
// - single bit: pull-up and response together; pulse response at end
// - infinite single bit pull-up stays on until F1 arrives
// - F1 outside data mode gives no response itself; pull-up released then pulse response
// - one received host byte is held while the previous one runs
// - C1 makes bus reset and presence detect; C9 means normal presence
// - data mode byte makes eight slots and returns sampled byte
// - duration codes 0 to 6 are fixed lengths, 7 is infinite
`timescale 1ns/1ps
`default_nettype none
module spq_sequencer #(
  parameter int SLOT_CYC = spq_pkg::us2cyc(spq_pkg::SLOT_US),
  parameter int LOW0_CYC = spq_pkg::us2cyc(spq_pkg::LOW0_US),
  parameter int RST_LOW_CYC = spq_pkg::us2cyc(spq_pkg::RST_LOW_US),
  parameter int RST_SMP_CYC = spq_pkg::us2cyc(spq_pkg::RST_SMP_US),
  parameter int RST_TOT_CYC = spq_pkg::us2cyc(spq_pkg::RST_TOT_US),
  parameter int SPU_BASE_CYC = spq_pkg::us2cyc(spq_pkg::SPU_BASE_US)
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_DATA,
  output logic CMD_READY,
  output logic RSP_VALID,
  output logic [7:0] RSP_DATA,
  input wire logic RSP_READY,
  input wire logic [2:0] SPU_DUR,
  input wire logic OW_IN,
  output logic OW_OUT,
  output logic OW_OE,
  output logic SPU_EN,
  output logic DATA_MODE,
  output logic SPU_ARMED
);
  localparam int LOW1_CYC = spq_pkg::us2cyc(spq_pkg::LOW1_US);
  localparam int SMP_CYC = LOW1_CYC + spq_pkg::us2cyc(spq_pkg::DSO_US);

  if (LOW0_CYC <= SMP_CYC || SLOT_CYC <= LOW0_CYC || RST_SMP_CYC <= RST_LOW_CYC ||
      RST_TOT_CYC <= RST_SMP_CYC || SPU_BASE_CYC < 1) begin : g_chk
    $error("spq_sequencer: inconsistent timing parameters");
  end

  logic [1:0] sync_reg;
  logic ow_s;
  logic rxf_reg, rxf_next, rdy_reg, rdy_next;
  logic [7:0] rxb_reg, rxb_next;
  spq_pkg::spq_state_t st_reg, st_next;
  logic [31:0] tmr_reg, tmr_next, dur_cyc, low_cyc;
  logic [7:0] sh_reg, sh_next, cmd_reg, cmd_next, pend_reg, pend_next, rdbyte;
  logic [2:0] bit_reg, bit_next;
  logic sb_reg, sb_next, smp_reg, smp_next, dm_reg, dm_next, arm_reg, arm_next;
  logic spu_reg, spu_next, drv_reg, drv_next, inf_reg, inf_next;
  logic pv_reg, pv_next, cons, push, pop;
  logic [7:0] hd_reg, hd_next, tl_reg, tl_next;
  logic hv_reg, hv_next, tv_reg, tv_next;

  assign ow_s = sync_reg[1];
  assign dur_cyc = 32'(SPU_BASE_CYC) << SPU_DUR;
  assign low_cyc = sh_reg[0] ? 32'(LOW1_CYC) : 32'(LOW0_CYC);
  assign rdbyte = {smp_reg, sh_reg[7:1]};
  assign push = pv_reg && !tv_reg;
  assign pop = hv_reg && RSP_READY;

  always_comb begin
    rxf_next = rxf_reg && !cons;
    rxb_next = rxb_reg;
    if (CMD_VALID && rdy_reg) begin
      rxf_next = 1'b1;
      rxb_next = CMD_DATA;
    end
    rdy_next = !rxf_next;
  end

  always_comb begin
    hd_next = hd_reg;
    hv_next = hv_reg;
    tl_next = tl_reg;
    tv_next = tv_reg;
    if (pop) begin
      hd_next = tl_reg;
      hv_next = tv_reg;
      tv_next = 1'b0;
    end
    if (push) begin
      if (!hv_next) begin
        hd_next = pend_reg;
        hv_next = 1'b1;
      end else begin
        tl_next = pend_reg;
        tv_next = 1'b1;
      end
    end
  end

  always_comb begin
    st_next = st_reg;
    tmr_next = tmr_reg + 32'h1;
    sh_next = sh_reg;
    cmd_next = cmd_reg;
    bit_next = bit_reg;
    sb_next = sb_reg;
    smp_next = smp_reg;
    dm_next = dm_reg;
    arm_next = arm_reg;
    spu_next = spu_reg;
    drv_next = drv_reg;
    inf_next = inf_reg;
    pend_next = pend_reg;
    pv_next = pv_reg && !push;
    cons = 1'b0;
    case (st_reg)
      spq_pkg::ST_IDLE: begin
        tmr_next = 32'h0;
        if (rxf_reg && !pv_reg) begin
          cons = 1'b1;
          cmd_next = rxb_reg;
          if (dm_reg) begin
            if (rxb_reg == spq_pkg::CMD_CMDM) begin
              dm_next = 1'b0;
            end else begin
              sh_next = rxb_reg;
              bit_next = 3'h0;
              sb_next = 1'b0;
              drv_next = 1'b1;
              st_next = spq_pkg::ST_SLOT;
            end
          end else if (rxb_reg == spq_pkg::CMD_DATA) begin
            dm_next = 1'b1;
          end else if (rxb_reg == spq_pkg::CMD_RESET) begin
            drv_next = 1'b1;
            st_next = spq_pkg::ST_RST;
          end else if ((rxb_reg & spq_pkg::PULSE_MASK) == spq_pkg::PULSE_VAL) begin
            arm_next = rxb_reg[spq_pkg::ARM_BIT];
            spu_next = 1'b1;
            inf_next = SPU_DUR == spq_pkg::DUR_INF;
            st_next = spq_pkg::ST_SPU;
          end else if ((rxb_reg & spq_pkg::SB_MASK) == spq_pkg::SB_VAL) begin
            sh_next = {7'h00, rxb_reg[spq_pkg::SB_BIT]};
            bit_next = 3'h0;
            sb_next = 1'b1;
            drv_next = 1'b1;
            st_next = spq_pkg::ST_SLOT;
          end
        end
      end
      spq_pkg::ST_RST: begin
        if (tmr_reg == 32'(RST_LOW_CYC - 1)) begin
          drv_next = 1'b0;
        end
        if (tmr_reg == 32'(RST_SMP_CYC - 1)) begin
          smp_next = ow_s;
        end
        if (tmr_reg == 32'(RST_TOT_CYC - 1)) begin
          pv_next = 1'b1;
          pend_next = smp_reg ? spq_pkg::RESP_NOPRES : spq_pkg::RESP_PRES;
          st_next = spq_pkg::ST_IDLE;
        end
      end
      spq_pkg::ST_SLOT: begin
        if (tmr_reg == low_cyc - 32'h1) begin
          drv_next = 1'b0;
        end
        if (tmr_reg == 32'(SMP_CYC - 1)) begin
          smp_next = ow_s;
        end
        if (tmr_reg == 32'(SLOT_CYC - 1)) begin
          tmr_next = 32'h0;
          if (sb_reg) begin
            pv_next = 1'b1;
            pend_next = (cmd_reg & spq_pkg::RESP_MASK) | {6'h00, smp_reg, smp_reg};
            if (cmd_reg[spq_pkg::ARM_BIT]) begin
              spu_next = 1'b1;
              inf_next = SPU_DUR == spq_pkg::DUR_INF;
              st_next = spq_pkg::ST_SPU;
            end else begin
              st_next = spq_pkg::ST_IDLE;
            end
          end else if (bit_reg == spq_pkg::LAST_BIT) begin
            pv_next = 1'b1;
            pend_next = rdbyte;
            if (arm_reg) begin
              spu_next = 1'b1;
              inf_next = SPU_DUR == spq_pkg::DUR_INF;
              st_next = spq_pkg::ST_SPU;
            end else begin
              st_next = spq_pkg::ST_IDLE;
            end
          end else begin
            sh_next = rdbyte;
            bit_next = bit_reg + 3'h1;
            drv_next = 1'b1;
          end
        end
      end
      spq_pkg::ST_SPU: begin
        if (!dm_reg && rxf_reg && rxb_reg == spq_pkg::CMD_TERM) begin
          cons = 1'b1;
          spu_next = 1'b0;
          st_next = spq_pkg::ST_FIN;
        end else if (!inf_reg && tmr_reg >= dur_cyc - 32'h1) begin
          spu_next = 1'b0;
          st_next = spq_pkg::ST_FIN;
        end
      end
      spq_pkg::ST_FIN: begin
        if (!pv_reg) begin
          pv_next = 1'b1;
          pend_next = dm_reg ? spq_pkg::RESP_SPU : cmd_reg & spq_pkg::RESP_MASK;
          st_next = spq_pkg::ST_IDLE;
        end
      end
      default: begin
        st_next = spq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync_reg <= 2'h0;
      rxf_reg <= 1'b0;
      rdy_reg <= 1'b0;
      rxb_reg <= 8'h00;
      st_reg <= spq_pkg::ST_IDLE;
      tmr_reg <= 32'h0;
      sh_reg <= 8'h00;
      cmd_reg <= 8'h00;
      pend_reg <= 8'h00;
      bit_reg <= 3'h0;
      sb_reg <= 1'b0;
      smp_reg <= 1'b0;
      dm_reg <= 1'b0;
      arm_reg <= 1'b0;
      spu_reg <= 1'b0;
      drv_reg <= 1'b0;
      inf_reg <= 1'b0;
      pv_reg <= 1'b0;
      hd_reg <= 8'h00;
      tl_reg <= 8'h00;
      hv_reg <= 1'b0;
      tv_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[0], OW_IN};
      rxf_reg <= rxf_next;
      rdy_reg <= rdy_next;
      rxb_reg <= rxb_next;
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      sh_reg <= sh_next;
      cmd_reg <= cmd_next;
      pend_reg <= pend_next;
      bit_reg <= bit_next;
      sb_reg <= sb_next;
      smp_reg <= smp_next;
      dm_reg <= dm_next;
      arm_reg <= arm_next;
      spu_reg <= spu_next;
      drv_reg <= drv_next;
      inf_reg <= inf_next;
      pv_reg <= pv_next;
      hd_reg <= hd_next;
      tl_reg <= tl_next;
      hv_reg <= hv_next;
      tv_reg <= tv_next;
    end
  end

  assign CMD_READY = rdy_reg;
  assign RSP_VALID = hv_reg;
  assign RSP_DATA = hd_reg;
  assign OW_OUT = 1'b0;
  assign OW_OE = drv_reg;
  assign SPU_EN = spu_reg;
  assign DATA_MODE = dm_reg;
  assign SPU_ARMED = arm_reg;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);

  wire idle_take = st_reg == spq_pkg::ST_IDLE && rxf_reg && !pv_reg;
  wire slot_end = st_reg == spq_pkg::ST_SLOT && tmr_reg == 32'(SLOT_CYC - 1);

  AST_ARM: assert property (idle_take && !dm_reg &&
    (rxb_reg & spq_pkg::PULSE_MASK) == spq_pkg::PULSE_VAL
    |=> arm_reg == $past(rxb_reg[spq_pkg::ARM_BIT]) && spu_reg)
    else $error("pulse command did not set arm state");
  AST_DATA_SPU: assert property (slot_end && !sb_reg && bit_reg == spq_pkg::LAST_BIT
    && arm_reg |=> spu_reg && pv_reg && pend_reg == $past(rdbyte))
    else $error("armed byte end without pull-up and response");
  AST_NO_SPU: assert property (slot_end && !sb_reg && bit_reg == spq_pkg::LAST_BIT
    && !arm_reg |=> !spu_reg && st_reg == spq_pkg::ST_IDLE)
    else $error("disarmed byte end raised pull-up");
  AST_SPU_END: assert property (st_reg == spq_pkg::ST_SPU && !spu_next
    |=> !SPU_EN ##[1:3] pv_reg)
    else $error("pulse response not queued after release");
  AST_STUCK: assert property (st_reg == spq_pkg::ST_SPU && dm_reg && inf_reg
    |=> st_reg == spq_pkg::ST_SPU && SPU_EN)
    else $error("infinite data-mode pull-up left");
  AST_F1_DATA: assert property (st_reg == spq_pkg::ST_SPU && dm_reg |-> !cons)
    else $error("termination consumed in data mode");
  AST_F1_END: assert property (st_reg == spq_pkg::ST_SPU && !dm_reg && rxf_reg
    && rxb_reg == spq_pkg::CMD_TERM |=> !SPU_EN && !rxf_reg ##1 pv_reg)
    else $error("termination did not end pull-up");
  AST_SB_SPU: assert property (slot_end && sb_reg && cmd_reg[spq_pkg::ARM_BIT]
    |=> SPU_EN && pv_reg)
    else $error("single bit pull-up missing");
  AST_HOLD: assert property (rxf_reg && !cons |=> rxf_reg && $stable(rxb_reg))
    else $error("held host byte lost");
  AST_RST: assert property (st_reg == spq_pkg::ST_RST && tmr_reg == 32'(RST_TOT_CYC - 1)
    && !smp_reg |=> pv_reg && pend_reg == spq_pkg::RESP_PRES)
    else $error("presence response wrong");
  AST_MODE: assert property (idle_take && !dm_reg && rxb_reg == spq_pkg::CMD_DATA
    |=> DATA_MODE && !pv_reg)
    else $error("data mode switch misbehaved");
endmodule : spq_sequencer
`default_nettype wire
